//--- pkg/dss_pkg.sv
// package of constants and carrier types for the dual supply sequencer
package dss_pkg;
    // clock rate in hz
    localparam int unsigned CLK_HZ = 10_000_000;
    // overcurrent qualification time in ns, then in cycles (least time, rounded up)
    localparam int unsigned OC_QUAL_NS = 1500;
    localparam int unsigned OC_QUAL_CYC = (OC_QUAL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // glitch filter for large dips, in us, then cycles
    localparam int unsigned GF_LARGE_US = 20;
    localparam int unsigned GF_LARGE_CYC = GF_LARGE_US * (CLK_HZ / 1_000_000);
    // glitch filter for small dips, in us, then cycles
    localparam int unsigned GF_SMALL_US = 80;
    localparam int unsigned GF_SMALL_CYC = GF_SMALL_US * (CLK_HZ / 1_000_000);
    // default timing cycle length in clock cycles
    localparam int unsigned TIMER_CYC_DEFAULT = 2_000_000;
    // counter widths
    localparam int unsigned TMR_W = 24;
    localparam int unsigned GF_W = 10;
    localparam int unsigned OC_W = 5;
    // gate drive command per channel
    typedef enum logic [1:0] {
        DSS_GATE_PULL = 2'h0,
        DSS_GATE_RAMP_DN = 2'h1,
        DSS_GATE_RAMP_UP = 2'h2
    } dss_gate_t;
    // request thresholds as digital flags
    typedef struct packed {
        logic above_low;
        logic above_mid;
        logic above_high;
    } dss_req_t;
    // supply monitor flags
    typedef struct packed {
        logic good;
        logic large_dip;
    } dss_mon_t;
endpackage

//--- core/dss_sync.sv
// three-stage synchroniser for a bus of asynchronous flags
`timescale 1ns/100ps
module dss_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    // metastability stages, first read only by second
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    // shift the flags through three flops
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // accept a new value per bit once second and third agree
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync_out <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (stage2[i] == stage3[i]) begin
                    sync_out[i] <= stage3[i];
                end
            end
        end
    end
endmodule

//--- core/dss_core.sv
// control logic of the dual supply sequencer
// What this block does
// R1 - monitor rising above threshold starts timing cycle
// R2 - release power-good after full cycle continuously high
// R3 - filtered monitor low drives power-good low
// R4 - short monitor highs keep power-good low
// R5 - glitch filter shorter for large dips
// R6 - idle timer held cleared at zero
// R7 - timer runs to trip, flags end, clears
// R8 - qualified overcurrent on either channel trips breaker
// R9 - breaker trip pulls both gates to ground
// R10 - breaker cleared by request low then high
// R11 - gate drive reenabled after post-clear cycle
// R12 - request starts cycle only when supplies good
// R13 - end of turn-on cycle enables gate drive
// R14 - request between low and mid ramps down
// R15 - request between mid and high ramps channel one
// R16 - request above high ramps channel two at once
// R17 - request dropping below high ramps channel two down
// R18 - request below lowest pulls all gates to ground
// R19 - outside pull-up needed on power-good output
// R20 - primary undervoltage disables, pulls channel one low
// R21 - both gates start pulled low
// R22 - trip held in sticky fault status flag
// R23 - timing cycle length is a clock-count parameter
`timescale 1ns/100ps
module dss_core
    import dss_pkg::*;
#(
    parameter int unsigned TIMER_CYC = TIMER_CYC_DEFAULT
) (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    // power request threshold flags from the pin comparators
    input wire dss_pkg::dss_req_t REQ_IN,
    // supply monitor comparator flags
    input wire dss_pkg::dss_mon_t MON_IN,
    // overcurrent comparators per channel
    input wire logic CHAN1_CURRENT_SENSE_IN,
    input wire logic CHAN2_CURRENT_SENSE_IN,
    // undervoltage detectors, high while rail is good
    input wire logic PRIMARY_SUPPLY_RAIL_GOOD_IN,
    input wire logic SECONDARY_SUPPLY_RAIL_GOOD_IN,
    // gate drive commands
    output dss_pkg::dss_gate_t CHAN1_PASS_DRIVE_OUT,
    output dss_pkg::dss_gate_t CHAN2_PASS_DRIVE_OUT,
    // active-low power-good, open drain
    output logic PWR_GOOD_B_OUT,
    output logic PWR_GOOD_OE_OUT,
    // status
    output logic FAULT_OUT,
    output logic MON_HIGH_OUT
);
    import dss_pkg::*;

    // turn-on state machine
    typedef enum logic [1:0] {
        DSS_OFF,
        DSS_TIMING,
        DSS_ON
    } dss_state_t;

    // synchronised inputs
    logic [8:0] sync_vec;
    dss_req_t req;
    dss_mon_t mon;
    logic oc1;
    logic oc2;
    logic uv1_good;
    logic uv2_good;
    logic req_low_d; // previous above_mid for edge detect
    logic req_rise;
    dss_state_t state;
    logic [TMR_W-1:0] tmr; // shared timer count
    logic tmr_on_run; // timer owned by turn-on
    logic tmr_mon_run; // timer owned by monitor
    logic tmr_done; // end of timing cycle pulse
    logic tmr_owner_on; // turn-on owned the timer last cycle
    logic mon_filt; // filtered monitor comparator
    logic [GF_W-1:0] gf_cnt; // dip duration
    logic [OC_W-1:0] oc_cnt; // overcurrent duration
    logic fault; // sticky breaker flag
    logic pg; // power-good released
    logic mon_timing; // monitor waiting for cycle
    logic gates_en; // charge drive enabled

    // all pin inputs cross into the clock domain
    dss_sync #(.W(9)) u_sync (
        .clk_in(CLK_IN),
        .rst_b_in(RST_B_IN),
        .async_in({REQ_IN, MON_IN, CHAN1_CURRENT_SENSE_IN, CHAN2_CURRENT_SENSE_IN,
            PRIMARY_SUPPLY_RAIL_GOOD_IN, SECONDARY_SUPPLY_RAIL_GOOD_IN}),
        .sync_out(sync_vec)
    );

    // unpack the synchronised flags
    assign req = dss_req_t'(sync_vec[8:6]);
    assign mon = dss_mon_t'(sync_vec[5:4]);
    assign oc1 = sync_vec[3];
    assign oc2 = sync_vec[2];
    assign uv1_good = sync_vec[1];
    assign uv2_good = sync_vec[0];
    // rising request edge at the middle threshold
    assign req_rise = req.above_mid && !req_low_d;

    // remember request level for edge detect
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            req_low_d <= 1'b0;
        end else begin
            req_low_d <= req.above_mid;
        end
    end

    // overcurrent qualification counter
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            oc_cnt <= '0;
        end else if (oc1 || oc2) begin
            // count continuous overcurrent, saturate at limit
            if (oc_cnt < OC_W'(OC_QUAL_CYC)) begin
                oc_cnt <= oc_cnt + 1'b1; // [R8]
            end
        end else begin
            oc_cnt <= '0;
        end
    end

    // sticky breaker flag, set wins over clear
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            fault <= 1'b0;
        end else if ((oc1 || oc2) && oc_cnt >= OC_W'(OC_QUAL_CYC)) begin
            fault <= 1'b1; // [R8] [R22]
        end else if (!req.above_low) begin
            fault <= 1'b0; // [R10] [R22]
        end
    end

    // turn-on sequence
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            state <= DSS_OFF;
        end else begin
            case (state)
                DSS_OFF: begin
                    // start only with good rails and no fault
                    if (req_rise && uv1_good && uv2_good && !fault) begin
                        state <= DSS_TIMING; // [R12] [R10]
                    end
                end
                DSS_TIMING: begin
                    // abort on drop, fault or primary undervoltage
                    if (!req.above_mid || fault || !uv1_good) begin
                        state <= DSS_OFF;
                    end else if (tmr_done) begin
                        state <= DSS_ON; // [R13] [R11]
                    end
                end
                DSS_ON: begin
                    // leave when request below mid, fault or primary undervoltage
                    if (!req.above_mid || fault || !uv1_good) begin
                        state <= DSS_OFF;
                    end
                end
                default: begin
                    state <= DSS_OFF;
                end
            endcase
        end
    end

    assign tmr_on_run = (state == DSS_TIMING);
    assign tmr_mon_run = mon_timing && !tmr_on_run;
    // no trip in a handover cycle: the count left by the other owner is stale
    assign tmr_done = (tmr_on_run || tmr_mon_run) && (tmr_on_run == tmr_owner_on) &&
        tmr == TMR_W'(TIMER_CYC - 1);
    assign gates_en = (state == DSS_ON);

    // shared timer, cleared when idle, at trip point and on handover
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            tmr <= '0;
            tmr_owner_on <= 1'b0;
        end else begin
            // a new owner always gets a full cycle
            tmr_owner_on <= tmr_on_run;
            if (!(tmr_on_run || tmr_mon_run) || tmr_done || tmr_on_run != tmr_owner_on) begin
                tmr <= '0; // [R6] [R7] [R23]
            end else begin
                tmr <= tmr + 1'b1; // [R7]
            end
        end
    end

    // glitch filter on the monitor comparator
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            gf_cnt <= '0;
            mon_filt <= 1'b0;
        end else if (mon.good) begin
            // rising edge passes at once
            gf_cnt <= '0;
            mon_filt <= 1'b1; // [R1]
        end else if (mon_filt) begin
            // large dips qualify after the short window
            if ((mon.large_dip && gf_cnt >= GF_W'(GF_LARGE_CYC - 1)) ||
                gf_cnt >= GF_W'(GF_SMALL_CYC - 1)) begin
                mon_filt <= 1'b0; // [R3] [R5]
                gf_cnt <= '0;
            end else begin
                gf_cnt <= gf_cnt + 1'b1; // [R5]
            end
        end
    end

    // power-good timing and release
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            mon_timing <= 1'b0;
            pg <= 1'b0;
        end else if (!mon_filt) begin
            // low monitor restarts; power-good pulled low
            mon_timing <= 1'b0; // [R4]
            pg <= 1'b0; // [R3]
        end else if (!pg && !mon_timing) begin
            mon_timing <= 1'b1; // [R1]
        end else if (tmr_mon_run && tmr_done) begin
            mon_timing <= 1'b0;
            pg <= 1'b1; // [R2]
        end
    end

    // channel one gate command
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            CHAN1_PASS_DRIVE_OUT <= DSS_GATE_PULL; // [R21]
        end else if (fault || !uv1_good) begin
            CHAN1_PASS_DRIVE_OUT <= DSS_GATE_PULL; // [R9] [R20]
        end else if (!req.above_low) begin
            CHAN1_PASS_DRIVE_OUT <= DSS_GATE_PULL; // [R18]
        end else if (gates_en) begin
            CHAN1_PASS_DRIVE_OUT <= DSS_GATE_RAMP_UP; // [R13] [R15]
        end else if (CHAN1_PASS_DRIVE_OUT != DSS_GATE_PULL) begin
            CHAN1_PASS_DRIVE_OUT <= DSS_GATE_RAMP_DN; // [R14]
        end
    end

    // channel two gate command
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            CHAN2_PASS_DRIVE_OUT <= DSS_GATE_PULL; // [R21]
        end else if (fault || !uv1_good) begin
            CHAN2_PASS_DRIVE_OUT <= DSS_GATE_PULL; // [R9]
        end else if (!req.above_low) begin
            CHAN2_PASS_DRIVE_OUT <= DSS_GATE_PULL; // [R18]
        end else if (gates_en && req.above_high) begin
            CHAN2_PASS_DRIVE_OUT <= DSS_GATE_RAMP_UP; // [R16]
        end else if (CHAN2_PASS_DRIVE_OUT != DSS_GATE_PULL) begin
            CHAN2_PASS_DRIVE_OUT <= DSS_GATE_RAMP_DN; // [R17] [R14]
        end
    end

    // open-drain power-good: drive low or release
    assign PWR_GOOD_B_OUT = 1'b0; // [R19]
    assign PWR_GOOD_OE_OUT = !pg;
    assign FAULT_OUT = fault;
    assign MON_HIGH_OUT = mon_filt;

    // trip pulls both gates at the next edge
    AST_TRIP_PULLS: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [R9]
        $rose(fault) |=> CHAN1_PASS_DRIVE_OUT == DSS_GATE_PULL &&
            CHAN2_PASS_DRIVE_OUT == DSS_GATE_PULL)
        else $error("gates not pulled after trip");
    AST_FAULT_NEEDS_OC: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [R8]
        $rose(fault) |-> $past(oc1 || oc2, 1) && $past(oc_cnt, 1) >= OC_W'(OC_QUAL_CYC))
        else $error("trip without qualified overcurrent");
    AST_FAULT_CLEAR: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [R10]
        $fell(fault) |-> $past(!req.above_low, 1))
        else $error("fault cleared without low request");
    AST_TMR_IDLE: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [R6]
        !(tmr_on_run || tmr_mon_run) |=> tmr == '0)
        else $error("idle timer not cleared");
    AST_TMR_WRAP: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [R7]
        tmr_done |=> tmr == '0)
        else $error("timer did not clear at trip");
    AST_PG_LOW: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [R3]
        $fell(mon_filt) |=> PWR_GOOD_OE_OUT)
        else $error("power-good not pulled low");
    AST_PG_CAUSE: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [R2]
        $rose(pg) |-> $past(tmr_done, 1) && $past(mon_filt, 1))
        else $error("power-good released without cycle");
    AST_START_GATED: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [R12]
        state == DSS_OFF && req_rise && (fault || !uv1_good || !uv2_good) |=> state == DSS_OFF)
        else $error("cycle started while blocked");
    AST_LOW_PULL: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [R18]
        !req.above_low |=> CHAN1_PASS_DRIVE_OUT == DSS_GATE_PULL)
        else $error("gate not pulled on low request");
    // end of turn-on in two steps: timer trip, then the on state
    sequence s_turn_on_done;
        state == DSS_TIMING && tmr_done ##1 state == DSS_ON;
    endsequence
    AST_RAMP_AFTER_CYCLE: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [R13]
        s_turn_on_done ##0 (!fault && uv1_good && req.above_low) |=>
            CHAN1_PASS_DRIVE_OUT == DSS_GATE_RAMP_UP)
        else $error("gate one not ramped after cycle");
    AST_CH2_AFTER_CYCLE: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [R16]
        $rose(CHAN2_PASS_DRIVE_OUT == DSS_GATE_RAMP_UP) |-> $past(gates_en, 1))
        else $error("gate two ramped before turn-on cycle");
endmodule

//--- testbench/dss_plant.sv
// far-side model: host reset line with its pull-up
`timescale 1ns/100ps
module dss_plant (
    // open-drain power-good pin from the sequencer
    input wire logic pg_b_in,
    input wire logic pg_oe_in,
    // resolved level seen by the host
    output wire logic reset_line_out
);
    // released pin floats up through the outside pull-up
    assign reset_line_out = pg_oe_in ? pg_b_in : 1'b1;
endmodule

//--- testbench/dual_supply_sequencer_bench.sv
// self-checking bench for the dual supply sequencer
`timescale 1ns/100ps
module dual_supply_sequencer_bench;
    import dss_pkg::*;
    // short timing cycle, still longer than the large-dip filter
    localparam int unsigned TCYC = 300;
    logic clk; // 10 mhz clock
    logic rst_b; // async reset, active low
    dss_req_t req; // request flags {low, mid, high}
    dss_mon_t mon; // monitor flags {good, large_dip}
    logic oc1, oc2; // overcurrent comparators
    logic rail1, rail2; // undervoltage detectors
    dss_gate_t g1, g2; // gate commands
    logic pg_b, pg_oe, fault, mon_hi, line;
    int n_mismatch; // failed comparisons
    int check_count; // all comparisons
    dss_core #(.TIMER_CYC(TCYC)) DUT (
        .CLK_IN(clk), .RST_B_IN(rst_b), .REQ_IN(req), .MON_IN(mon),
        .CHAN1_CURRENT_SENSE_IN(oc1), .CHAN2_CURRENT_SENSE_IN(oc2),
        .PRIMARY_SUPPLY_RAIL_GOOD_IN(rail1), .SECONDARY_SUPPLY_RAIL_GOOD_IN(rail2),
        .CHAN1_PASS_DRIVE_OUT(g1), .CHAN2_PASS_DRIVE_OUT(g2),
        .PWR_GOOD_B_OUT(pg_b), .PWR_GOOD_OE_OUT(pg_oe),
        .FAULT_OUT(fault), .MON_HIGH_OUT(mon_hi)
    );
    // host side with pull-up
    dss_plant plant (.pg_b_in(pg_b), .pg_oe_in(pg_oe), .reset_line_out(line));
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // pick an observed output: 1 chan1_pass_drive, 2 chan2_pass_drive, 3 reset line, 4 fault
    function automatic logic [1:0] probe(input int w);
        case (w)
            1: probe = g1;
            2: probe = g2;
            3: probe = {1'b0, line};
            default: probe = {1'b0, fault};
        endcase
    endfunction
    // print counts and verdict, then stop
    task complete_run;
        $display("mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // count one comparison, report a miss
    task note(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    // bounded wait for a level; running out ends the run
    task await(input int w, input logic [1:0] exp, input int bound);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < bound && !hit; i++) begin
            @(negedge clk);
            hit = (probe(w) === exp);
        end
        note(hit, $sformatf("output %0d never reached %0d", w, exp));
        if (!hit) begin
            complete_run();
        end
    endtask
    // level must stay put for n cycles
    task hold(input int w, input logic [1:0] exp, input int n);
        repeat (n) begin
            @(negedge clk);
            note(probe(w) === exp, $sformatf("output %0d left %0d", w, exp));
        end
    endtask
    // staged turn-on: channel one after a cycle, channel two at once
    task t_turn_on;
        req = 3'b110;
        hold(1, DSS_GATE_PULL, TCYC - 10);
        await(1, DSS_GATE_RAMP_UP, 30);
        note(g2 === DSS_GATE_PULL, "chan2_pass_drive moved below high");
        req = 3'b111;
        await(2, DSS_GATE_RAMP_UP, 8);
    endtask
    // short monitor high is forgotten, full cycle releases the line
    task t_monitor;
        mon = 2'b10;
        hold(3, 2'h0, 50);
        mon = 2'b01;
        hold(3, 2'h0, 400);
        mon = 2'b10;
        hold(3, 2'h0, TCYC - 10);
        await(3, 2'h1, 30);
        note(mon_hi === 1'b1, "monitor flag low");
    endtask
    // dips shorter than their window are ignored
    task t_dips;
        mon = 2'b01;
        hold(3, 2'h1, 100);
        mon = 2'b10;
        hold(3, 2'h1, 20);
        mon = 2'b00;
        hold(3, 2'h1, 400);
        mon = 2'b10;
        hold(3, 2'h1, 20);
        mon = 2'b01;
        hold(3, 2'h1, 180);
        await(3, 2'h0, 40);
        mon = 2'b10;
        await(3, 2'h1, TCYC + 30);
        // small dip trips only after the long window
        mon = 2'b00;
        hold(3, 2'h1, 780);
        await(3, 2'h0, 40);
        mon = 2'b10;
    endtask
    // stepwise power-down through each threshold band
    task t_down;
        req = 3'b110;
        await(2, DSS_GATE_RAMP_DN, 8);
        note(g1 === DSS_GATE_RAMP_UP, "chan1_pass_drive left ramp up");
        req = 3'b100;
        await(1, DSS_GATE_RAMP_DN, 8);
        req = 3'b000;
        await(1, DSS_GATE_PULL, 8);
        note(g2 === DSS_GATE_PULL, "chan2_pass_drive not pulled");
    endtask
    // breaker qualification, trip, sticky flag and clearing order
    task t_breaker;
        req = 3'b110;
        await(1, DSS_GATE_RAMP_UP, TCYC + 30);
        oc2 = 1'b1;
        repeat (10) @(negedge clk);
        oc2 = 1'b0;
        hold(4, 2'h0, 20);
        oc1 = 1'b1;
        await(4, 2'h1, 25);
        await(1, DSS_GATE_PULL, 2);
        note(g2 === DSS_GATE_PULL, "chan2_pass_drive not pulled on trip");
        oc1 = 1'b0;
        // mid edge without going below low must not clear
        req = 3'b100;
        repeat (10) @(negedge clk);
        req = 3'b110;
        hold(4, 2'h1, TCYC + 20);
        note(g1 === DSS_GATE_PULL, "chan1_pass_drive moved while tripped");
        req = 3'b000;
        await(4, 2'h0, 10);
        req = 3'b110;
        hold(1, DSS_GATE_PULL, TCYC - 10);
        await(1, DSS_GATE_RAMP_UP, 30);
    endtask
    // either rail low blocks the start
    task t_lockout;
        // primary rail lost while running pulls gate one
        rail1 = 1'b0;
        await(1, DSS_GATE_PULL, 8);
        req = 3'b000;
        repeat (10) @(negedge clk);
        req = 3'b110;
        hold(1, DSS_GATE_PULL, TCYC + 20);
        req = 3'b000;
        rail1 = 1'b1;
        rail2 = 1'b0;
        repeat (10) @(negedge clk);
        req = 3'b110;
        hold(1, DSS_GATE_PULL, TCYC + 20);
        rail2 = 1'b1;
    endtask
    // main sequence
    initial begin
        rst_b = 1'b0;
        req = 3'b000;
        mon = 2'b00;
        oc1 = 1'b0;
        oc2 = 1'b0;
        rail1 = 1'b1;
        rail2 = 1'b1;
        n_mismatch = 0;
        check_count = 0;
        repeat (4) @(negedge clk);
        note(g1 === DSS_GATE_PULL && g2 === DSS_GATE_PULL, "gates not pulled");
        note(line === 1'b0 && fault === 1'b0, "reset state wrong");
        rst_b = 1'b1;
        t_turn_on();
        t_monitor();
        t_dips();
        t_down();
        t_breaker();
        t_lockout();
        complete_run();
    end
endmodule
